// file: attr_table_consts.svh
// attr_table_consts.svh: frame codes, handle limits and timing counts
// for the attribute table maintenance command handler.
// assumes a 250 MHz system clock.
`ifndef ATTR_TABLE_CONSTS_SVH
`define ATTR_TABLE_CONSTS_SVH

// ----------------------------------------------------------------------
// frame header codes
// ----------------------------------------------------------------------
`define FRM_TYPE_CMD 8'hC0
`define FRM_GROUP_TABLE 8'h05
`define ID_DELETE 8'h02
`define ID_VALIDATE 8'h03
`define ID_STORE 8'h04
`define ID_DUMP 8'h05
`define ID_ENTRY_EVT 8'h04
`define FRM_TYPE_EVT 8'h80
`define LEN_DELETE_CMD 8'h02
`define LEN_DELETE_RSP 8'h08
`define LEN_VALIDATE_RSP 8'h04
`define LEN_STORE_RSP 8'h02
`define LEN_DUMP_CMD 8'h01
`define LEN_DUMP_RSP 8'h04
`define LEN_ENTRY_EVT 8'h02
`define TXT_LEN_STORE 16'h000B

// ----------------------------------------------------------------------
// handles and validity codes
// ----------------------------------------------------------------------
`define HANDLE_FIRST_FIXED 16'h0001
`define HANDLE_LAST_FIXED 16'h001C
`define HANDLE_FIRST_USER 16'h001D
`define VALID_OK 16'h0000
`define VALID_TOO_FEW 16'h0001

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define NV_BUSY_MS 15
`define NV_BUSY_CYCLES ((`NV_BUSY_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// file: attr_table_pkg.sv
// attr_table_pkg.sv: types shared by the attribute table command handler.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package attr_table_pkg;

  // handler states, one-hot
  typedef enum logic [6:0] {
    ST_HDR   = 7'h01,
    ST_PAY   = 7'h02,
    ST_EXEC  = 7'h04,
    ST_NVW   = 7'h08,
    ST_RSP   = 7'h10,
    ST_EVT   = 7'h20,
    ST_DRAIN = 7'h40
  } state_t;

endpackage : attr_table_pkg

`default_nettype wire

// file: attr_table_maint.sv
// attr_table_maint.sv: command handler for delete, validate, store and dump
// of the local attribute table, with non-volatile write busy period.
// assumes decoded serial bytes arrive one per rx_valid pulse and tx bytes are
// accepted one per cycle while tx_ready is high; the table store keeps only
// the count of attributes, the attribute content lives elsewhere.
//
// Function
// - handle zero removes only the newest, highest-numbered attribute
// - text delete without handle acts as handle zero
// - non-zero handle removes that attribute and all higher ones
// - handles below 0x001D are fixed and never deleted
// - every table change is committed to non-volatile storage
// - device busy about 15 ms per write, received bytes dropped
// - with flow control, incoming data is held off during writes
// - delete carries one 16-bit handle, lowest attribute to remove
// - delete answer: count removed, next free handle, validity code
// - validity check runs after each create or delete
// - validate takes no argument, answers one 16-bit validity code
// - code 0x0000 valid, 0x0001 too few attributes
// - additions producing other non-valid states are rejected
// - store is accepted, answered without parameters, does nothing
// - text store answer reports length 0x000B
// - dump emits one entry event per attribute in range
// - include-fixed 0 starts at 0x001D, 1 starts at 0x0001
// - dump answer carries count of events to follow
`include "attr_table_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module attr_table_maint #(
  parameter int NV_BUSY = `NV_BUSY_CYCLES,
  parameter logic [15:0] MIN_ATTRS = 16'h0003
)(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic text_mode,
  input wire logic text_no_arg,
  input wire logic flow_ctrl_en,
  input wire logic add_req,
  input wire logic add_bad,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic rx_hold,
  output logic nv_busy,
  output logic add_reject,
  output logic [15:0] table_top,
  output logic [15:0] text_rsp_len
);

  // ----------------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------------
  attr_table_pkg::state_t state_reg, state_next;
  logic [7:0] hdr_reg [0:3];
  logic [7:0] arg_reg [0:1];
  logic [1:0] idx_reg;
  logic [15:0] top_reg;
  logic [15:0] removed_reg;
  logic [15:0] dump_h_reg;
  logic [15:0] dump_cnt_reg;
  logic [31:0] busy_reg;
  logic [3:0] tx_idx_reg;
  logic [3:0] tx_last_reg;
  logic [7:0] rsp_reg [0:11];

  // validity of a table whose top handle is given
  function automatic logic [15:0] validity(input logic [15:0] top);
    validity = (top - `HANDLE_LAST_FIXED < MIN_ATTRS) ? `VALID_TOO_FEW : `VALID_OK;
  endfunction : validity

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  wire logic hdr_ok = hdr_reg[0] == `FRM_TYPE_CMD && hdr_reg[2] == `FRM_GROUP_TABLE;
  wire logic is_del = hdr_ok && hdr_reg[3] == `ID_DELETE;
  wire logic is_val = hdr_ok && hdr_reg[3] == `ID_VALIDATE;
  wire logic is_sto = hdr_ok && hdr_reg[3] == `ID_STORE;
  wire logic is_dmp = hdr_ok && hdr_reg[3] == `ID_DUMP;
  wire logic [7:0] pay_len = hdr_reg[1];
  wire logic rx_take = rx_valid && busy_reg == 32'd0;
  wire logic [15:0] del_arg = (text_mode && text_no_arg) ? 16'h0000 : {arg_reg[1], arg_reg[0]};
  // zero removes only the newest, otherwise the named handle and above
  wire logic [15:0] del_from = (del_arg == 16'h0000) ? top_reg : del_arg;
  wire logic del_legal = del_from >= `HANDLE_FIRST_USER && del_from <= top_reg;
  wire logic [15:0] del_cnt = del_legal ? top_reg - del_from + 16'h0001 : 16'h0000;
  wire logic [15:0] new_top = del_legal ? del_from - 16'h0001 : top_reg;
  wire logic [15:0] dmp_start = arg_reg[0][0] ? `HANDLE_FIRST_FIXED : `HANDLE_FIRST_USER;
  wire logic [15:0] dmp_cnt = (top_reg >= dmp_start) ? top_reg - dmp_start + 16'h0001 : 16'h0000;
  wire logic [15:0] cur_valid = validity(top_reg);
  wire logic tx_go = tx_valid && tx_ready;
  // byte on the wire for the current or next index
  wire logic [3:0] tx_sel = tx_go ? tx_idx_reg + 4'd1 : tx_idx_reg;
  wire logic [7:0] evt_byte = tx_sel == 4'd0 ? `FRM_TYPE_EVT : tx_sel == 4'd1 ? `LEN_ENTRY_EVT :
    tx_sel == 4'd2 ? `FRM_GROUP_TABLE : tx_sel == 4'd3 ? `ID_ENTRY_EVT :
    tx_sel == 4'd4 ? dump_h_reg[7:0] : dump_h_reg[15:8];
  wire logic [7:0] tx_byte = state_reg == attr_table_pkg::ST_EVT ?
    ((tx_go && tx_idx_reg == 4'd5) ? `FRM_TYPE_EVT : evt_byte) : rsp_reg[tx_sel];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      attr_table_pkg::ST_HDR:
        if (rx_take && idx_reg == 2'd3)
          state_next = attr_table_pkg::ST_PAY;
      attr_table_pkg::ST_PAY:
        if (pay_len == 8'h00 || (rx_take && {6'd0, idx_reg} == pay_len - 8'h01) || idx_reg == 2'd2)
          state_next = attr_table_pkg::ST_EXEC;
      attr_table_pkg::ST_EXEC:
        if (is_del && del_legal)
          state_next = attr_table_pkg::ST_NVW;
        else if (is_del || is_val || is_sto || is_dmp)
          state_next = attr_table_pkg::ST_RSP;
        else
          state_next = attr_table_pkg::ST_HDR;
      attr_table_pkg::ST_NVW:
        if (busy_reg == 32'd1)
          state_next = attr_table_pkg::ST_RSP;
      attr_table_pkg::ST_RSP:
        if (tx_go && tx_idx_reg == tx_last_reg)
          state_next = (is_dmp && dump_cnt_reg != 16'h0000) ? attr_table_pkg::ST_EVT : attr_table_pkg::ST_HDR;
      attr_table_pkg::ST_EVT:
        if (tx_go && tx_idx_reg == 4'd5 && dump_cnt_reg == 16'h0001)
          state_next = attr_table_pkg::ST_HDR;
      default:
        state_next = attr_table_pkg::ST_HDR;
    endcase
  end

  // ----------------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_reg <= attr_table_pkg::ST_HDR;
      idx_reg <= 2'd0;
      arg_reg[0] <= 8'h00;
      arg_reg[1] <= 8'h00;
      for (int i = 0; i < 4; i++)
        hdr_reg[i] <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      // bytes outside header and payload capture are dropped
      if (state_reg == attr_table_pkg::ST_HDR && rx_take)
      begin
        hdr_reg[idx_reg] <= rx_data;
        idx_reg <= idx_reg + 2'd1;
        if (idx_reg == 2'd3)
        begin
          idx_reg <= 2'd0;
          arg_reg[0] <= 8'h00;
          arg_reg[1] <= 8'h00;
        end
      end
      else if (state_reg == attr_table_pkg::ST_PAY && rx_take && idx_reg < 2'd2)
      begin
        arg_reg[idx_reg[0]] <= rx_data;
        idx_reg <= idx_reg + 2'd1;
      end
      else if (state_reg != attr_table_pkg::ST_PAY && state_reg != attr_table_pkg::ST_HDR)
        idx_reg <= 2'd0;
    end
  end

  // ----------------------------------------------------------------------
  // table, busy timer and dump walk
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      top_reg <= `HANDLE_LAST_FIXED;
      removed_reg <= 16'h0000;
      busy_reg <= 32'd0;
      dump_h_reg <= 16'h0000;
      dump_cnt_reg <= 16'h0000;
      add_reject <= 1'b0;
    end
    else
    begin
      add_reject <= 1'b0;
      if (busy_reg != 32'd0)
        busy_reg <= busy_reg - 32'd1;
      if (state_reg == attr_table_pkg::ST_EXEC && is_del)
      begin
        removed_reg <= del_cnt;
        top_reg <= new_top;
        if (del_legal)
          busy_reg <= NV_BUSY;
      end
      else if (state_reg == attr_table_pkg::ST_EXEC && is_dmp)
      begin
        dump_h_reg <= dmp_start;
        dump_cnt_reg <= dmp_cnt;
      end
      else if (state_reg == attr_table_pkg::ST_HDR && add_req && idx_reg == 2'd0)
      begin
        // additions checked against the table rules, then committed
        if (add_bad || top_reg == 16'hFFFF)
          add_reject <= 1'b1;
        else
        begin
          top_reg <= top_reg + 16'h0001;
          busy_reg <= NV_BUSY;
        end
      end
      if (state_reg == attr_table_pkg::ST_EVT && tx_go && tx_idx_reg == 4'd5)
      begin
        dump_h_reg <= dump_h_reg + 16'h0001;
        dump_cnt_reg <= dump_cnt_reg - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // answer frame builder
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      tx_idx_reg <= 4'd0;
      tx_last_reg <= 4'd0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      for (int i = 0; i < 12; i++)
        rsp_reg[i] <= 8'h00;
    end
    else
    begin
      if (state_next == attr_table_pkg::ST_RSP && state_reg != attr_table_pkg::ST_RSP)
      begin
        rsp_reg[0] <= `FRM_TYPE_CMD;
        rsp_reg[2] <= `FRM_GROUP_TABLE;
        rsp_reg[3] <= hdr_reg[3];
        tx_idx_reg <= 4'd0;
        if (is_del)
        begin
          rsp_reg[1] <= `LEN_DELETE_RSP;
          {rsp_reg[5], rsp_reg[4]} <= 16'h0000;
          {rsp_reg[7], rsp_reg[6]} <= (state_reg == attr_table_pkg::ST_NVW) ? removed_reg : del_cnt;
          {rsp_reg[9], rsp_reg[8]} <= top_reg + 16'h0001;
          {rsp_reg[11], rsp_reg[10]} <= cur_valid;
          tx_last_reg <= 4'd11;
        end
        else if (is_sto)
        begin
          rsp_reg[1] <= `LEN_STORE_RSP;
          {rsp_reg[5], rsp_reg[4]} <= 16'h0000;
          tx_last_reg <= 4'd5;
        end
        else
        begin
          rsp_reg[1] <= is_val ? `LEN_VALIDATE_RSP : `LEN_DUMP_RSP;
          {rsp_reg[5], rsp_reg[4]} <= 16'h0000;
          {rsp_reg[7], rsp_reg[6]} <= is_val ? cur_valid : dmp_cnt;
          tx_last_reg <= 4'd7;
        end
        tx_valid <= 1'b0;
      end
      else if (state_reg == attr_table_pkg::ST_RSP && state_next == attr_table_pkg::ST_EVT)
      begin
        tx_idx_reg <= 4'd0;
        tx_valid <= 1'b0;
      end
      else if (state_reg == attr_table_pkg::ST_RSP || state_reg == attr_table_pkg::ST_EVT)
      begin
        if (tx_go)
          tx_idx_reg <= (state_reg == attr_table_pkg::ST_EVT && tx_idx_reg == 4'd5) ? 4'd0 : tx_idx_reg + 4'd1;
        tx_valid <= !(tx_go && state_next == attr_table_pkg::ST_HDR);
        tx_data <= tx_byte;
      end
      else
        tx_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rx_hold <= 1'b0;
      nv_busy <= 1'b0;
      table_top <= 16'h0000;
      text_rsp_len <= 16'h0000;
    end
    else
    begin
      nv_busy <= busy_reg != 32'd0;
      rx_hold <= flow_ctrl_en && busy_reg != 32'd0;
      table_top <= top_reg;
      text_rsp_len <= is_sto ? `TXT_LEN_STORE : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  fixed_kept_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    top_reg >= `HANDLE_LAST_FIXED) else $error("fixed attributes removed");
  hold_busy_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (flow_ctrl_en && busy_reg != 32'd0) |=> rx_hold) else $error("rx not held during write");
  nv_commit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == attr_table_pkg::ST_EXEC && is_del && del_legal) |=> busy_reg == NV_BUSY)
    else $error("delete not committed");
  del_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == attr_table_pkg::ST_EXEC && is_del && del_arg == 16'h0000 && del_legal)
    |=> top_reg == $past(top_reg) - 16'h0001) else $error("zero delete wrong");
  valid_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cur_valid == `VALID_OK || cur_valid == `VALID_TOO_FEW) else $error("bad validity");
  reject_add_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == attr_table_pkg::ST_HDR && add_req && idx_reg == 2'd0 && add_bad)
    |=> add_reject && $stable(top_reg)) else $error("bad add accepted");
  dump_start_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == attr_table_pkg::ST_EXEC && is_dmp && !arg_reg[0][0])
    |=> dump_h_reg == `HANDLE_FIRST_USER) else $error("dump start wrong");
  store_len_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    is_sto |=> text_rsp_len == `TXT_LEN_STORE) else $error("store length wrong");

endmodule : attr_table_maint

`default_nettype wire

// file: host_model.sv
// host_model.sv: far-side host that sends command frames and sinks answers.
// assumes the handler holds each answer byte until tx_ready is high.
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready
);
  logic [7:0] got [$];

  // idle line levels at time zero
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // one byte, one valid pulse; a released line shows no stale byte
  task automatic send_byte(input logic [7:0] b);
    @(posedge sys_clk);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : send_byte

  // header of type, length, group and identifier, then low byte first
  task automatic send_frame(input logic [7:0] id, input logic [7:0] len, input logic [15:0] arg);
    send_byte(8'hC0);
    send_byte(len);
    send_byte(8'h05);
    send_byte(id);
    if (len > 8'h00) send_byte(arg[7:0]);
    if (len > 8'h01) send_byte(arg[15:8]);
  endtask : send_frame

  // answer sink, stalls every other cycle when slow
  always @(posedge sys_clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule : host_model

`default_nettype wire

// file: tb_attr_table_maint.sv
// tb_attr_table_maint.sv: self-checking bench for the table command handler.
// assumes host_model.sv and a write busy count shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none

module tb_attr_table_maint;
  typedef struct packed {logic [7:0] id; logic [7:0] len; logic [15:0] arg; logic tm; logic na;
    logic [15:0] cnt; logic [15:0] nxt; logic [15:0] vld;} row_t;
  logic sys_clk, nrst, text_mode, text_no_arg, flow_ctrl_en, add_req, add_bad, slow;
  logic rx_valid, tx_ready, tx_valid, rx_hold, nv_busy, add_reject;
  logic [7:0] rx_data, tx_data;
  logic [15:0] table_top, text_rsp_len;
  int miscompares, samples_checked, busy_n, hold_n, k;
  row_t rows [10];

  attr_table_maint #(.NV_BUSY(20)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .rx_data(rx_data),
    .rx_valid(rx_valid), .text_mode(text_mode), .text_no_arg(text_no_arg), .flow_ctrl_en(flow_ctrl_en),
    .add_req(add_req), .add_bad(add_bad), .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .rx_hold(rx_hold), .nv_busy(nv_busy), .add_reject(add_reject), .table_top(table_top),
    .text_rsp_len(text_rsp_len));
  host_model host_u (.sys_clk(sys_clk), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));

  // ----------------------------------------------------------------------
  // clock, busy counters and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (nv_busy === 1'b1) busy_n++;
    if (rx_hold === 1'b1) hold_n++;
  end

  initial
  begin
    #200000;
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------------
  // compare, verdict, table additions and one command
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic add(input logic bad);
    logic seen;
    seen = 1'b0;
    @(posedge sys_clk);
    add_req <= 1'b1;
    add_bad <= bad;
    @(posedge sys_clk);
    add_req <= 1'b0;
    repeat (4) @(posedge sys_clk) seen |= (add_reject === 1'b1);
    chk("add_reject", {15'h0000, seen}, {15'h0000, bad});
  endtask : add

  task automatic run(input row_t r);
    logic [7:0] e [$];
    logic [15:0] f [$];
    logic [15:0] h;
    int b0, h0;
    f = {16'h0000};
    if (r.id == 8'h02) f = {f, r.cnt, r.nxt, r.vld};
    if (r.id == 8'h03) f.push_back(r.vld);
    if (r.id == 8'h05) f.push_back(r.cnt);
    e = {8'hC0, 8'(2 * f.size()), 8'h05, r.id};
    foreach (f[i]) e = {e, f[i][7:0], f[i][15:8]};
    for (int i = 0; r.id == 8'h05 && i < int'(r.cnt); i++)
    begin
      h = r.nxt + 16'(i);
      e = {e, 8'h80, 8'h02, 8'h05, 8'h04, h[7:0], h[15:8]};
    end
    @(posedge sys_clk);
    text_mode <= r.tm;
    text_no_arg <= r.na;
    host_u.got.delete();
    b0 = busy_n;
    h0 = hold_n;
    host_u.send_frame(r.id, r.len, r.arg);
    for (int i = 0; i < 2000 && host_u.got.size() < e.size(); i++) @(posedge sys_clk);
    repeat (25) @(posedge sys_clk);
    chk("rsp_bytes", 16'(host_u.got.size()), 16'(e.size()));
    foreach (e[i]) chk("rsp_byte", {8'h00, host_u.got[i]}, {8'h00, e[i]});
    chk("text_rsp_len", text_rsp_len, (r.id == 8'h04) ? 16'h000B : 16'h0000);
    chk("nv_busy", 16'(busy_n - b0 >= 20), 16'(r.id == 8'h02 && r.cnt != 16'h0));
    chk("rx_hold", 16'(hold_n - h0), flow_ctrl_en ? 16'(busy_n - b0) : 16'h0000);
    if (r.id == 8'h02) chk("table_top", table_top, r.nxt - 16'h0001);
    $display("done command %h arg %h", r.id, r.arg);
  endtask : run

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {nrst, text_mode, text_no_arg, add_req, add_bad} = 5'h00;
    flow_ctrl_en = 1'b1;
    slow = 1'b1;
    // command, length, argument, text, no-arg, count, next or first handle, validity
    rows[0] = '{8'h03, 8'h00, 16'h0000, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000};
    rows[1] = '{8'h04, 8'h00, 16'h0000, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000};
    rows[2] = '{8'h05, 8'h01, 16'h0000, 1'b0, 1'b0, 16'h0005, 16'h001D, 16'h0000};
    rows[3] = '{8'h02, 8'h02, 16'h0000, 1'b0, 1'b0, 16'h0001, 16'h0021, 16'h0000};
    rows[4] = '{8'h02, 8'h02, 16'h001F, 1'b0, 1'b0, 16'h0002, 16'h001F, 16'h0001};
    rows[5] = '{8'h02, 8'h02, 16'h0010, 1'b0, 1'b0, 16'h0000, 16'h001F, 16'h0001};
    rows[6] = '{8'h02, 8'h02, 16'h001D, 1'b1, 1'b1, 16'h0001, 16'h001E, 16'h0001};
    rows[7] = '{8'h02, 8'h02, 16'h0022, 1'b0, 1'b0, 16'h0000, 16'h001E, 16'h0001};
    rows[8] = '{8'h05, 8'h01, 16'h0001, 1'b0, 1'b0, 16'h001D, 16'h0001, 16'h0001};
    rows[9] = '{8'h03, 8'h00, 16'h0000, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0001};
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("table_top", table_top, 16'h001C);
    chk("tx_valid", {15'h0000, tx_valid}, 16'h0000);
    chk("nv_busy", {15'h0000, nv_busy}, 16'h0000);
    $display("done reset checks");
    // five user attributes, then a refused addition
    repeat (5) add(1'b0);
    add(1'b1);
    repeat (25) @(posedge sys_clk);
    chk("table_top", table_top, 16'h0021);
    $display("done additions");
    foreach (rows[i]) run(rows[i]);
    // a byte sent during the write busy period must be dropped
    flow_ctrl_en <= 1'b0;
    slow <= 1'b0;
    add(1'b0);
    add(1'b0);
    host_u.send_byte(8'hC0);
    repeat (25) @(posedge sys_clk);
    fork
      run('{8'h02, 8'h02, 16'h0000, 1'b0, 1'b0, 16'h0001, 16'h001F, 16'h0001});
      begin
        for (k = 0; k < 500 && nv_busy !== 1'b1; k++) @(posedge sys_clk);
        host_u.send_byte(8'hC0);
      end
    join
    run(rows[9]);
    close_out();
  end
endmodule : tb_attr_table_maint

`default_nettype wire
